// *** logic/tcc_top.sv ***
// Input capture and two output compare channels with APB registers
// ----------------------------------------------------------------
// ----------------------------------------------------------------
`timescale 1ns/100ps
module tcc_top (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic capture_pin,
   input wire logic comparator_output,
   input wire logic [15:0] counter_value,
   input wire logic timer_tick,
   input wire logic counter_write,
   input wire logic at_top,
   input wire logic at_bottom,
   input wire logic irq_ack_cap,
   input wire logic irq_ack_cmpa,
   input wire logic irq_ack_cmpb,
   output logic irq_cap,
   output logic irq_cmpa,
   output logic irq_cmpb,
   output logic [1:0] compare_output,
   output logic [1:0] compare_match
);
   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      tcc_pkg::tcc_bus_t bus; // Bus phase
      logic [31:0] rdata; // Read data
      logic ready; // Access-phase ready
      logic err; // Slave error
      logic [15:0] ctrl; // Control bits
      logic [2:0] flags; // Capture, compare A, compare B
      logic [2:0] irqen; // Interrupt enables
      logic [7:0] temp; // Shared high-byte latch
      logic [15:0] cap; // Capture register
      logic [1:0][15:0] cmp_buf; // Compare buffers
      logic [1:0][15:0] cmp_act; // Active compare values
      logic [1:0] oc; // Compare output state
      logic [1:0] match; // Match pulse outputs
      logic [1:0] match_pend; // Match seen, flag next tick
      logic block; // Block matches on next tick
      logic [3:0] samp; // Filter sample history
      logic filt; // Filtered level
      logic edge_prev; // Previous edge detector input
      logic [2:0] irq; // Interrupt outputs
   } tcc_state_t;

   tcc_state_t s_reg; // Registered state
   tcc_state_t s_next; // Next state

   // ----------------------------------------------------------------
   // Decoded controls
   // ----------------------------------------------------------------
   logic [3:0] wgm; // Waveform mode bits
   logic cap_top; // Mode uses capture as top
   logic pwm; // Any of the PWM modes
   logic trig_raw; // Selected trigger source
   logic edge_in; // Edge detector input
   logic cap_evt; // Capture event this cycle
   logic [1:0] eq; // Counter equals active compare
   logic wr_acc; // Write access completes
   logic rd_acc; // Read access completes
   logic [1:0][1:0] act; // Action bits per channel
   logic [1:0] force_st; // Force strobes written

   assign wgm = s_reg.ctrl[tcc_pkg::CTRL_WGM_LSB +: 4];
   assign act[0] = s_reg.ctrl[tcc_pkg::CTRL_ACTA_LSB +: 2];
   assign act[1] = s_reg.ctrl[tcc_pkg::CTRL_ACTB_LSB +: 2];
   // Capture-top modes: these free the capture register as a top value
   assign cap_top = (wgm == tcc_pkg::WGM_CTC_CAP) || (wgm == tcc_pkg::WGM_PWM_PFC_CAP)
                 || (wgm == tcc_pkg::WGM_PWM_PC_CAP) || (wgm == tcc_pkg::WGM_FAST_CAP);
   // Everything but normal and the two clear-on-match codes is PWM
   assign pwm = (wgm != tcc_pkg::WGM_NORMAL) && (wgm != tcc_pkg::WGM_CTC_A)
             && (wgm != tcc_pkg::WGM_CTC_CAP);
   // Source mux; pin is taken as already synchronous
   assign trig_raw = s_reg.ctrl[tcc_pkg::CTRL_SRC] ? comparator_output : capture_pin;
   // Filtered or raw level feeds the edge detector
   assign edge_in = s_reg.ctrl[tcc_pkg::CTRL_FILT] ? s_reg.filt : trig_raw;
   // Edge qualified by polarity; gated off in capture-top modes
   assign cap_evt = !cap_top && (edge_in != s_reg.edge_prev)
                 && (edge_in == s_reg.ctrl[tcc_pkg::CTRL_EDGE]);
   // Accesses complete only in the ready cycle, so one edge per transfer
   assign wr_acc = psel && penable && pwrite && s_reg.ready;
   assign rd_acc = psel && penable && !pwrite && s_reg.ready;
   // Force strobes are dropped in PWM modes, where they would corrupt the wave
   assign force_st = (wr_acc && paddr == tcc_pkg::ADDR_FORCE && !pwm) ? pwdata[1:0] : 2'h0;

   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++)
      begin : g_eq
         // Continuous 16-bit compare
         assign eq[gi] = (counter_value == s_reg.cmp_act[gi]);
      end
   endgenerate

   // ----------------------------------------------------------------
   // Next-state logic
   // ----------------------------------------------------------------
   always_comb
   begin
      s_next = s_reg;
      s_next.match = 2'h0;
      // Filter shifts every system clock, independent of prescaler
      s_next.samp = {s_reg.samp[2:0], trig_raw};
      if (s_reg.samp == {tcc_pkg::FILT_LEN{1'b1}})
      begin
         s_next.filt = 1'b1;
      end
      else if (s_reg.samp == {tcc_pkg::FILT_LEN{1'b0}})
      begin
         s_next.filt = 1'b0;
      end
      s_next.edge_prev = edge_in;
      // Bus: one wait state, ready in second access cycle
      s_next.ready = 1'b0;
      case (s_reg.bus)
         tcc_pkg::TCC_IDLE:
         begin
            if (psel && penable)
            begin
               s_next.bus = tcc_pkg::TCC_ACCESS;
               s_next.ready = 1'b1;
            end
         end
         tcc_pkg::TCC_ACCESS:
         begin
            s_next.bus = tcc_pkg::TCC_IDLE;
         end
         default:
         begin
            s_next.bus = tcc_pkg::TCC_IDLE;
         end
      endcase
      // Read data and error prepared while the request stands
      s_next.rdata = 32'h0000_0000;
      s_next.err = 1'b0;
      case (paddr)
         tcc_pkg::ADDR_CTRL: s_next.rdata = {16'h0000, s_reg.ctrl};
         tcc_pkg::ADDR_FLAGS: s_next.rdata = {29'h0, s_reg.flags};
         tcc_pkg::ADDR_IRQEN: s_next.rdata = {29'h0, s_reg.irqen};
         tcc_pkg::ADDR_FORCE: s_next.rdata = 32'h0000_0000;
         tcc_pkg::ADDR_CAP_LO: s_next.rdata = {24'h0, s_reg.cap[7:0]};
         tcc_pkg::ADDR_CAP_HI: s_next.rdata = {24'h0, s_reg.temp};
         // Compare reads bypass the latch
         tcc_pkg::ADDR_CMPA_LO: s_next.rdata = {24'h0, s_reg.cmp_buf[0][7:0]};
         tcc_pkg::ADDR_CMPA_HI: s_next.rdata = {24'h0, s_reg.cmp_buf[0][15:8]};
         tcc_pkg::ADDR_CMPB_LO: s_next.rdata = {24'h0, s_reg.cmp_buf[1][7:0]};
         tcc_pkg::ADDR_CMPB_HI: s_next.rdata = {24'h0, s_reg.cmp_buf[1][15:8]};
         tcc_pkg::ADDR_OUTST: s_next.rdata = {30'h0, s_reg.oc};
         default: s_next.err = 1'b1; // Unmapped answers with error
      endcase
      // Low-byte read of capture loads the latch
      if (rd_acc && paddr == tcc_pkg::ADDR_CAP_LO)
      begin
         s_next.temp = s_reg.cap[15:8];
      end
      // Register writes
      if (wr_acc)
      begin
         case (paddr)
            // Action bits take effect at once, no buffering
            tcc_pkg::ADDR_CTRL: s_next.ctrl = pwdata[15:0];
            tcc_pkg::ADDR_IRQEN: s_next.irqen = pwdata[2:0];
            tcc_pkg::ADDR_CAP_HI, tcc_pkg::ADDR_CMPA_HI, tcc_pkg::ADDR_CMPB_HI:
            begin
               s_next.temp = pwdata[7:0];
            end
            tcc_pkg::ADDR_CAP_LO:
            begin
               if (cap_top)
               begin
                  s_next.cap = {s_reg.temp, pwdata[7:0]};
               end
            end
            tcc_pkg::ADDR_CMPA_LO: s_next.cmp_buf[0] = {s_reg.temp, pwdata[7:0]};
            tcc_pkg::ADDR_CMPB_LO: s_next.cmp_buf[1] = {s_reg.temp, pwdata[7:0]};
            default: s_next.temp = s_reg.temp;
         endcase
      end
      // In PWM, active compare values load on a tick at top or bottom; bypass buffer outside PWM
      for (int i = 0; i < 2; i++)
      begin
         if (!pwm)
         begin
            s_next.cmp_act[i] = s_next.cmp_buf[i];
         end
         else if (timer_tick && (at_top || at_bottom))
         begin
            s_next.cmp_act[i] = s_reg.cmp_buf[i];
         end
      end
      // Capture overwrites unread value, flag same cycle
      if (cap_evt)
      begin
         s_next.cap = counter_value;
      end
      // Counter write arms blocking until next timer tick
      if (counter_write)
      begin
         s_next.block = 1'b1;
      end
      else if (timer_tick)
      begin
         s_next.block = 1'b0;
      end
      // Flag clears: ack or write one; a set in the same cycle wins
      if (irq_ack_cap || (wr_acc && paddr == tcc_pkg::ADDR_FLAGS && pwdata[tcc_pkg::FLG_CAP]))
      begin
         s_next.flags[tcc_pkg::FLG_CAP] = 1'b0;
      end
      if (irq_ack_cmpa || (wr_acc && paddr == tcc_pkg::ADDR_FLAGS && pwdata[tcc_pkg::FLG_CMPA]))
      begin
         s_next.flags[tcc_pkg::FLG_CMPA] = 1'b0;
      end
      if (irq_ack_cmpb || (wr_acc && paddr == tcc_pkg::ADDR_FLAGS && pwdata[tcc_pkg::FLG_CMPB]))
      begin
         s_next.flags[tcc_pkg::FLG_CMPB] = 1'b0;
      end
      if (cap_evt)
      begin
         s_next.flags[tcc_pkg::FLG_CAP] = 1'b1;
      end
      // Compare channels: match seen, flag and output at next tick
      for (int i = 0; i < 2; i++)
      begin
         if (timer_tick)
         begin
            s_next.match_pend[i] = eq[i] && !s_reg.block && !counter_write;
            if (s_reg.match_pend[i])
            begin
               s_next.flags[tcc_pkg::FLG_CMPA + i] = 1'b1;
               s_next.match[i] = 1'b1;
               case (act[i])
                  tcc_pkg::ACT_TOGGLE: s_next.oc[i] = !s_reg.oc[i];
                  tcc_pkg::ACT_CLEAR: s_next.oc[i] = 1'b0;
                  tcc_pkg::ACT_SET: s_next.oc[i] = 1'b1;
                  default: s_next.oc[i] = s_reg.oc[i]; // Kept across modes
               endcase
            end
         end
         // Forced compare moves the output only
         if (force_st[i])
         begin
            case (act[i])
               tcc_pkg::ACT_TOGGLE: s_next.oc[i] = !s_reg.oc[i];
               tcc_pkg::ACT_CLEAR: s_next.oc[i] = 1'b0;
               tcc_pkg::ACT_SET: s_next.oc[i] = 1'b1;
               default: s_next.oc[i] = s_next.oc[i];
            endcase
         end
      end
      // Interrupt requests gated by enables
      s_next.irq = s_next.flags & s_next.irqen;
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         // Output state, flags and latch all cleared to zero
         s_reg <= '0;
      end
      else
      begin
         s_reg <= s_next;
      end
   end

   // Outputs straight from flops
   assign prdata = s_reg.rdata;
   assign pready = s_reg.ready;
   assign pslverr = s_reg.err;
   assign irq_cap = s_reg.irq[tcc_pkg::FLG_CAP];
   assign irq_cmpa = s_reg.irq[tcc_pkg::FLG_CMPA];
   assign irq_cmpb = s_reg.irq[tcc_pkg::FLG_CMPB];
   assign compare_output = s_reg.oc;
   assign compare_match = s_reg.match;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   // Capture side
   a_cap_copy: assert property (@(posedge pclk) disable iff (!presetn)
      cap_evt |=> (s_reg.cap == $past(counter_value)))
      else $error("capture did not copy counter");
   a_cap_flag: assert property (@(posedge pclk) disable iff (!presetn)
      cap_evt |=> s_reg.flags[tcc_pkg::FLG_CAP])
      else $error("capture flag not set with capture");
   a_cap_irq: assert property (@(posedge pclk) disable iff (!presetn)
      (s_reg.flags[tcc_pkg::FLG_CAP] && s_reg.irqen[tcc_pkg::FLG_CAP]) |-> irq_cap)
      else $error("capture irq missing");
   a_cap_ack: assert property (@(posedge pclk) disable iff (!presetn)
      (irq_ack_cap && !cap_evt) |=> !s_reg.flags[tcc_pkg::FLG_CAP])
      else $error("capture flag not cleared by service");
   a_latch_load: assert property (@(posedge pclk) disable iff (!presetn)
      (rd_acc && paddr == tcc_pkg::ADDR_CAP_LO && !cap_evt) |=> s_reg.temp == s_reg.cap[15:8])
      else $error("latch not loaded");
   a_cap_wr_block: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_acc && !cap_top && !cap_evt) |=> $stable(s_reg.cap))
      else $error("capture written outside capture-top mode");
   a_no_edge_top: assert property (@(posedge pclk) disable iff (!presetn)
      cap_top |-> !cap_evt)
      else $error("capture in capture-top mode");
   a_filter_hold: assert property (@(posedge pclk) disable iff (!presetn)
      (s_reg.samp != 4'h0 && s_reg.samp != 4'hF) |=> $stable(s_reg.filt))
      else $error("filter changed without four samples");

   // Compare side
   a_match_flag: assert property (@(posedge pclk) disable iff (!presetn)
      (timer_tick && s_reg.match_pend[0]) |=> s_reg.flags[tcc_pkg::FLG_CMPA])
      else $error("compare flag not set");
   a_match_flag_b: assert property (@(posedge pclk) disable iff (!presetn)
      (timer_tick && s_reg.match_pend[1]) |=> s_reg.flags[tcc_pkg::FLG_CMPB])
      else $error("compare flag B not set");
   a_cmpa_irq: assert property (@(posedge pclk) disable iff (!presetn)
      (s_reg.flags[tcc_pkg::FLG_CMPA] && s_reg.irqen[tcc_pkg::FLG_CMPA]) |-> irq_cmpa)
      else $error("compare irq missing");
   a_cmp_bypass: assert property (@(posedge pclk) disable iff (!presetn)
      !pwm |=> (s_reg.cmp_act == s_reg.cmp_buf))
      else $error("compare buffer not bypassed");
   a_pwm_hold: assert property (@(posedge pclk) disable iff (!presetn)
      (pwm && !(timer_tick && (at_top || at_bottom))) |=> $stable(s_reg.cmp_act))
      else $error("compare value moved between top and bottom");
   a_block_match: assert property (@(posedge pclk) disable iff (!presetn)
      (counter_write && timer_tick) |=> !s_reg.match_pend[0] && !s_reg.match_pend[1])
      else $error("match not blocked after counter write");
   a_block_tick: assert property (@(posedge pclk) disable iff (!presetn)
      (timer_tick && s_reg.block) |=> !s_reg.match_pend[0] && !s_reg.match_pend[1])
      else $error("match not blocked in tick after counter write");
   a_force_noflag: assert property (@(posedge pclk) disable iff (!presetn)
      (force_st[0] && !(timer_tick && s_reg.match_pend[0])
         && !s_reg.flags[tcc_pkg::FLG_CMPA]) |=> !s_reg.flags[tcc_pkg::FLG_CMPA])
      else $error("force set the flag");
   a_force_set: assert property (@(posedge pclk) disable iff (!presetn)
      (force_st[0] && act[0] == tcc_pkg::ACT_SET) |=> compare_output[0])
      else $error("force did not set the output");
endmodule : tcc_top

// *** logic/tcc_pkg.sv ***
// Constants, register map and mode codes for the timer capture/compare block
package tcc_pkg;
   // ----------------------------------------------------------------
   // Register byte addresses (APB, one aligned word each)
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_CTRL = 8'h00; // Mode, edge, filter, source, actions
   localparam logic [7:0] ADDR_FLAGS = 8'h04; // Flags, write one to clear
   localparam logic [7:0] ADDR_IRQEN = 8'h08; // Interrupt enables
   localparam logic [7:0] ADDR_FORCE = 8'h0C; // Force strobes, write only
   localparam logic [7:0] ADDR_CAP_LO = 8'h10; // Capture low byte
   localparam logic [7:0] ADDR_CAP_HI = 8'h14; // Capture high byte
   localparam logic [7:0] ADDR_CMPA_LO = 8'h18; // Compare A low byte
   localparam logic [7:0] ADDR_CMPA_HI = 8'h1C; // Compare A high byte
   localparam logic [7:0] ADDR_CMPB_LO = 8'h20; // Compare B low byte
   localparam logic [7:0] ADDR_CMPB_HI = 8'h24; // Compare B high byte
   localparam logic [7:0] ADDR_OUTST = 8'h28; // Compare output state, read only
   // ----------------------------------------------------------------
   // Control register field positions
   // ----------------------------------------------------------------
   localparam int CTRL_WGM_LSB = 0; // Four waveform mode bits
   localparam int CTRL_EDGE = 4; // 1 = rising edge
   localparam int CTRL_FILT = 5; // Noise filter enable
   localparam int CTRL_SRC = 6; // Comparator capture select
   localparam int CTRL_ACTA_LSB = 8; // Output action bits A
   localparam int CTRL_ACTB_LSB = 10; // Output action bits B
   localparam int FLG_CAP = 0; // Capture flag bit
   localparam int FLG_CMPA = 1; // Compare flag A bit
   localparam int FLG_CMPB = 2; // Compare flag B bit
   // ----------------------------------------------------------------
   // Mode codes and misc
   // ----------------------------------------------------------------
   localparam logic [3:0] WGM_NORMAL = 4'h0; // Normal mode
   localparam logic [3:0] WGM_CTC_A = 4'h4; // Clear on match, top from A
   localparam logic [3:0] WGM_CTC_CAP = 4'hC; // Clear on match, top from capture
   localparam logic [3:0] WGM_PWM_PFC_CAP = 4'h8; // PWM top from capture
   localparam logic [3:0] WGM_PWM_PC_CAP = 4'hA; // PWM top from capture
   localparam logic [3:0] WGM_FAST_CAP = 4'hE; // Fast PWM top from capture
   localparam logic [1:0] ACT_NONE = 2'h0; // No action
   localparam logic [1:0] ACT_TOGGLE = 2'h1; // Toggle
   localparam logic [1:0] ACT_CLEAR = 2'h2; // Clear
   localparam logic [1:0] ACT_SET = 2'h3; // Set
   localparam int FILT_LEN = 4; // Equal samples required
   localparam logic [15:0] CTRL_RESET = 16'h0000; // Control reset value
   // Bus state
   typedef enum logic [1:0] {
      TCC_IDLE = 2'b00,
      TCC_ACCESS = 2'b01
   } tcc_bus_t;
endpackage : tcc_pkg

// *** tb/tcc_counter_model.sv ***
// Behavioural counter unit model driving the capture/compare block
`timescale 1ns/100ps
module tcc_counter_model #(
   parameter logic [15:0] TOP = 16'h00FF // Top value seen by the buffer logic
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic load, // Load strobe from the bench
   input wire logic [15:0] load_val, // Value to load
   output logic [15:0] counter_value,
   output logic timer_tick,
   output logic at_top,
   output logic at_bottom
);
   logic [1:0] div_reg; // Prescaler, one tick every four cycles
   // ----------------------------------------------------------------
   // Counter holds still; only loads move it, so captures are exact
   // ----------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         div_reg <= 2'h0;
         timer_tick <= 1'b0;
         counter_value <= 16'h0000;
      end
      else
      begin
         div_reg <= div_reg + 2'h1;
         timer_tick <= (div_reg == 2'h3);
         if (load)
            counter_value <= load_val;
      end
   end
   assign at_top = (counter_value == TOP);
   assign at_bottom = (counter_value == 16'h0000);
endmodule : tcc_counter_model

// *** tb/tb.sv ***
// Register level testbench of the capture/compare block
`timescale 1ns/100ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin num_errors++; \
   $display("[ERR] %s exp %h got %h", nm, e, g); end end
module tb;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, capture_pin = 1'b0, comparator_output = 1'b0, counter_write = 1'b0;
   logic load = 1'b0, timer_tick, at_top, at_bottom, irq_ack_cap = 1'b0;
   logic irq_cap, irq_cmpa, irq_cmpb, err;
   logic [15:0] counter_value, load_val = 16'h0;
   logic [1:0] compare_output, compare_match;
   int num_errors = 0, comparisons = 0, mca = 0, mcb = 0, base;
   // ----------------------------------------------------------------
   // Clock, partner and design
   // ----------------------------------------------------------------
   always #25 pclk = ~pclk;
   tcc_counter_model CNT (.pclk(pclk), .presetn(presetn), .load(load), .load_val(load_val),
      .counter_value(counter_value), .timer_tick(timer_tick), .at_top(at_top),
      .at_bottom(at_bottom));
   tcc_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .capture_pin(capture_pin), .comparator_output(comparator_output),
      .counter_value(counter_value), .timer_tick(timer_tick), .counter_write(counter_write),
      .at_top(at_top), .at_bottom(at_bottom), .irq_ack_cap(irq_ack_cap),
      .irq_ack_cmpa(1'b0), .irq_ack_cmpb(1'b0), .irq_cap(irq_cap), .irq_cmpa(irq_cmpa),
      .irq_cmpb(irq_cmpb), .compare_output(compare_output), .compare_match(compare_match));
   // Match pulse tallies; scenarios compare against a snapshot
   always @(posedge pclk)
   begin
      mca <= mca + compare_match[0];
      mcb <= mcb + compare_match[1];
   end
   // ----------------------------------------------------------------
   // Bus and stimulus tasks
   // ----------------------------------------------------------------
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // Bounded wait for the one-cycle ready pulse
      for (n = 0; n < 40; n++)
      begin
         @(posedge pclk);
         if (pready === 1'b1)
            break;
      end
      if (n == 40)
         num_errors++;
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask : wr
   task automatic chk(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      `CHK("read data", e, rd)
   endtask : chk
   // Counter load doubles as the CPU counter write strobe
   task automatic setcnt(input logic [15:0] v);
      @(posedge pclk);
      load <= 1'b1;
      load_val <= v;
      counter_write <= 1'b1;
      @(posedge pclk);
      load <= 1'b0;
      counter_write <= 1'b0;
   endtask : setcnt
   task automatic pin(input logic v);
      @(posedge pclk);
      capture_pin <= v;
      repeat (10) @(posedge pclk);
   endtask : pin
   task automatic stop_test;
      $display("Comparisons %0d, mismatches %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : stop_test
   // Watchdog well beyond the few hundred cycles the tests need
   initial
   begin
      #1000000;
      num_errors++;
      stop_test();
   end
   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial
   begin
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      chk(tcc_pkg::ADDR_CTRL, 32'h0);
      chk(tcc_pkg::ADDR_OUTST, 32'h0);
      chk(8'h3C, 32'h0);
      `CHK("slave error", 1'b1, err)
      // Park both compares far away, high byte first
      wr(tcc_pkg::ADDR_CMPA_HI, 32'hFF);
      wr(tcc_pkg::ADDR_CMPA_LO, 32'hF0);
      wr(tcc_pkg::ADDR_CMPB_HI, 32'hFF);
      wr(tcc_pkg::ADDR_CMPB_LO, 32'hF0);
      chk(tcc_pkg::ADDR_CMPA_HI, 32'hFF);
      chk(tcc_pkg::ADDR_CMPA_LO, 32'hF0);
      wr(tcc_pkg::ADDR_CTRL, 32'h10);
      setcnt(16'h1234);
      wr(tcc_pkg::ADDR_FLAGS, 32'h7);
      pin(1'b1);
      chk(tcc_pkg::ADDR_FLAGS, 32'h1);
      // Capture not writable in normal mode
      wr(tcc_pkg::ADDR_CAP_HI, 32'h55);
      wr(tcc_pkg::ADDR_CAP_LO, 32'h66);
      chk(tcc_pkg::ADDR_CAP_LO, 32'h34);
      chk(tcc_pkg::ADDR_CAP_HI, 32'h12);
      wr(tcc_pkg::ADDR_FLAGS, 32'h1);
      pin(1'b0);
      chk(tcc_pkg::ADDR_FLAGS, 32'h0);
      setcnt(16'hABCD);
      pin(1'b1);
      chk(tcc_pkg::ADDR_CAP_LO, 32'hCD);
      chk(tcc_pkg::ADDR_CAP_HI, 32'hAB);
      wr(tcc_pkg::ADDR_IRQEN, 32'h1);
      @(posedge pclk);
      `CHK("irq_cap", 1'b1, irq_cap)
      @(posedge pclk);
      irq_ack_cap <= 1'b1;
      @(posedge pclk);
      irq_ack_cap <= 1'b0;
      repeat (3) @(posedge pclk);
      `CHK("irq_cap", 1'b0, irq_cap)
      // Falling edge polarity
      wr(tcc_pkg::ADDR_CTRL, 32'h00);
      setcnt(16'h0102);
      pin(1'b0);
      chk(tcc_pkg::ADDR_CAP_LO, 32'h02);
      // Filter: short glitch ignored, held level not flagged four cycles later, flagged twelve cycles later
      wr(tcc_pkg::ADDR_CTRL, 32'h20);
      pin(1'b1);
      wr(tcc_pkg::ADDR_FLAGS, 32'h1);
      @(posedge pclk);
      capture_pin <= 1'b0;
      repeat (2) @(posedge pclk);
      pin(1'b1);
      `CHK("irq_cap", 1'b0, irq_cap)
      @(posedge pclk);
      capture_pin <= 1'b0;
      repeat (4) @(posedge pclk);
      `CHK("irq_cap", 1'b0, irq_cap)
      repeat (8) @(posedge pclk);
      `CHK("irq_cap", 1'b1, irq_cap)
      // Comparator as source; flag cleared after the switch
      wr(tcc_pkg::ADDR_CTRL, 32'h50);
      wr(tcc_pkg::ADDR_FLAGS, 32'h1);
      @(posedge pclk);
      comparator_output <= 1'b1;
      repeat (10) @(posedge pclk);
      `CHK("irq_cap", 1'b1, irq_cap)
      // Capture-top mode: mode first, then high then low
      wr(tcc_pkg::ADDR_CTRL, 32'h1C);
      wr(tcc_pkg::ADDR_FLAGS, 32'h1);
      wr(tcc_pkg::ADDR_CAP_HI, 32'hAB);
      wr(tcc_pkg::ADDR_CAP_LO, 32'hCD);
      chk(tcc_pkg::ADDR_CAP_LO, 32'hCD);
      chk(tcc_pkg::ADDR_CAP_HI, 32'hAB);
      pin(1'b1);
      `CHK("irq_cap", 1'b0, irq_cap)
      // Compare A with set action; counter write blocks one tick
      wr(tcc_pkg::ADDR_CTRL, 32'h0310);
      wr(tcc_pkg::ADDR_CMPA_HI, 32'h00);
      wr(tcc_pkg::ADDR_CMPA_LO, 32'h10);
      wr(tcc_pkg::ADDR_FLAGS, 32'h7);
      base = mca;
      setcnt(16'h0010);
      repeat (2) @(posedge pclk iff timer_tick);
      repeat (2) @(posedge pclk);
      `CHK("match A", 0, mca - base)
      repeat (12) @(posedge pclk);
      `CHK("match A seen", 1'b1, mca > base)
      `CHK("output A", 1'b1, compare_output[0])
      chk(tcc_pkg::ADDR_FLAGS, 32'h2);
      wr(tcc_pkg::ADDR_IRQEN, 32'h2);
      repeat (2) @(posedge pclk);
      `CHK("irq_cmpa", 1'b1, irq_cmpa)
      // Force with changed action, no flag
      setcnt(16'h0005);
      wr(tcc_pkg::ADDR_CTRL, 32'h0210);
      wr(tcc_pkg::ADDR_FLAGS, 32'h7);
      wr(tcc_pkg::ADDR_FORCE, 32'h1);
      @(posedge pclk);
      `CHK("output A", 1'b0, compare_output[0])
      chk(tcc_pkg::ADDR_FLAGS, 32'h0);
      wr(tcc_pkg::ADDR_CTRL, 32'h0310);
      wr(tcc_pkg::ADDR_FORCE, 32'h1);
      wr(tcc_pkg::ADDR_CTRL, 32'h031E);
      @(posedge pclk);
      `CHK("output A", 1'b1, compare_output[0])
      wr(tcc_pkg::ADDR_CTRL, 32'h021E);
      wr(tcc_pkg::ADDR_FORCE, 32'h1);
      @(posedge pclk);
      `CHK("output A", 1'b1, compare_output[0])
      // PWM buffer: held until the counter reaches top
      setcnt(16'h0030);
      base = mcb;
      wr(tcc_pkg::ADDR_CMPB_HI, 32'h00);
      wr(tcc_pkg::ADDR_CMPB_LO, 32'h30);
      repeat (20) @(posedge pclk);
      `CHK("match B", 0, mcb - base)
      chk(tcc_pkg::ADDR_CMPB_LO, 32'h30);
      setcnt(16'h00FF);
      repeat (10) @(posedge pclk);
      setcnt(16'h0030);
      repeat (20) @(posedge pclk);
      `CHK("match B seen", 1'b1, mcb > base)
      stop_test();
   end
endmodule : tb
